// ---- src/rst_defines.svh ----
// Offsets, field positions and timing counts of the reset and wake block.
`ifndef RST_DEFINES_SVH
`define RST_DEFINES_SVH
// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_RESET_CTRL     12'h000
`define ADDR_WAKE_STATUS    12'h004
`define ADDR_CLOCK_CONFIG   12'h008
// ****************************************************************
// Field positions of the reset control register
// ****************************************************************
`define BIT_PRIO_EN         7
`define BIT_SOFT_BOR        6
`define BIT_RI              4
`define BIT_WDT_TO          3
`define BIT_PWR_DOWN        2
`define BIT_POWER_ON        1
`define BIT_BROWN_OUT       0
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS       100
`define OST_OSC_PERIODS     1024
`define PLL_LOCK_US         2000
`define PLL_LOCK_CYCLES     ((`PLL_LOCK_US * 1000) / `CLK_PERIOD_NS)
`define CSD_CYCLES_DEF      4
`define IOBST_CYCLES_DEF    16
`define MASTER_CLEAR_PIN_FILTER_DEF     3
`endif

// ---- src/rst_pkg.sv ----
// Types shared by the reset and wake block.
package rst_pkg;
   typedef enum logic [1:0] {
      CLK_PRIMARY_IDLE = 2'b00,
      CLK_SLOW_RC      = 2'b01,
      CLK_INT_OSC_MUX  = 2'b11,
      CLK_NONE_SLEEP   = 2'b10
   } pre_clk_t;
   typedef enum logic [1:0] {
      OSC_CRYSTAL = 2'b00,
      OSC_PLL     = 2'b01,
      OSC_EXT     = 2'b11,
      OSC_INT     = 2'b10
   } post_clk_t;
   typedef enum logic [1:0] {
      WS_RUN  = 2'b00,
      WS_WAIT = 2'b01,
      WS_DONE = 2'b11
   } wake_state_t;
endpackage

// ---- src/reset_status_wake_exit.sv ----
// Reset-cause register, master-clear filter and wake-exit sequencer with AXI4-Lite access.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "rst_defines.svh"
module reset_status_wake_exit #(
   parameter int PLL_CYCLES   = `PLL_LOCK_CYCLES,
   parameter int OST_CYCLES   = `OST_OSC_PERIODS,
   parameter int CSD_CYCLES   = `CSD_CYCLES_DEF,
   parameter int IOBST_CYCLES = `IOBST_CYCLES_DEF,
   parameter int FILT_CYCLES  = `MASTER_CLEAR_PIN_FILTER_DEF
) (
   input  wire logic                mclk,
   input  wire logic                reset_n,
   input  wire logic [11:0]         s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [11:0]         s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                power_on_event,
   input  wire logic                brownout_event,
   input  wire logic                reset_instr_event,
   input  wire logic                watchdog_timeout_event,
   input  wire logic                stack_full_event,
   input  wire logic                stack_underflow_event,
   input  wire logic                watchdog_clear_instr,
   input  wire logic                sleep_instr,
   input  wire logic                in_power_managed,
   input  wire logic [1:0]          brownout_config_mode,
   input  wire logic                master_clear_pin_enable,
   input  wire logic                master_clear_pin_in,
   output logic                     master_clear_pin_out,
   output logic                     master_clear_pin_oe,
   output logic                     master_clear_digital_in,
   input  wire logic                wake_event,
   input  wire rst_pkg::pre_clk_t   pre_wake_clock,
   input  wire rst_pkg::post_clk_t  post_wake_clock,
   input  wire logic                osc_tick,
   output logic                     device_reset,
   output logic                     cpu_run,
   output logic                     primary_clock_ready,
   output logic                     internal_osc_stable,
   output logic                     brownout_active,
   output logic                     interrupt_priority_enable,
   output logic [3:0]               reset_cause
);
   import rst_pkg::*;

   // ****************************************************************
   // Master-clear filter
   // ****************************************************************
   logic [7:0] filt_cnt_q;
   logic       master_clear_pin_q;
   logic       bor_arm_q;
   // Pin is input only; the device never pulls it, even on watchdog reset.
   assign master_clear_pin_out = 1'b0;
   assign master_clear_pin_oe  = 1'b0;
   // When disabled the pin is handed to the port logic as plain input.
   assign master_clear_digital_in = master_clear_pin_enable ? 1'b0 : master_clear_pin_in;

   // A low level must persist FILT_CYCLES before it counts, so glitches pass unseen.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         filt_cnt_q <= 8'h00;
         master_clear_pin_q     <= 1'b0;
      end else if (!master_clear_pin_enable || master_clear_pin_in) begin
         filt_cnt_q <= 8'h00;
         master_clear_pin_q     <= 1'b0;
      end else if (filt_cnt_q >= 8'(FILT_CYCLES - 1)) begin
         master_clear_pin_q <= 1'b1;
      end else begin
         filt_cnt_q <= filt_cnt_q + 8'h01;
      end
   end

   // ****************************************************************
   // Reset control and status register
   // ****************************************************************
   logic       prio_q, soft_bor_q, ri_q, to_q, pd_q, por_q, bor_q;
   logic       wr_go, soft_mode, fw_wr;
   logic [7:0] wbyte;
   logic [3:0] cause_q;
   assign soft_mode = (brownout_config_mode == 2'b01);
   assign device_reset = master_clear_pin_q | power_on_event | brownout_event | reset_instr_event
                       | watchdog_timeout_event | stack_full_event | stack_underflow_event;
   assign interrupt_priority_enable = prio_q;
   assign brownout_active = (brownout_config_mode == 2'b11) || (brownout_config_mode == 2'b10
                          && !pd_q) || (soft_mode && soft_bor_q);
   assign reset_cause = cause_q;

   // Priority and soft brown-out controls; power-on restores their defaults.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prio_q     <= 1'b0;
         soft_bor_q <= 1'b0;
         bor_arm_q  <= 1'b1;
      end else if (bor_arm_q || power_on_event) begin
         // Default taken after release so the mode pins are sampled by a clock.
         prio_q     <= 1'b0;
         soft_bor_q <= soft_mode;
         bor_arm_q  <= 1'b0;
      end else if (fw_wr) begin
         prio_q     <= wbyte[`BIT_PRIO_EN];
         soft_bor_q <= wbyte[`BIT_SOFT_BOR] & soft_mode;
      end
   end

   // Low flags: firmware may only set RI, power-on and brown-out; events clear and win.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ri_q  <= 1'b1;
         to_q  <= 1'b1;
         pd_q  <= 1'b1;
         por_q <= 1'b0;
         bor_q <= 1'b0;
      end else begin
         if (reset_instr_event) ri_q <= 1'b0;
         else if (fw_wr && wbyte[`BIT_RI]) ri_q <= 1'b1;
         if (watchdog_timeout_event) to_q <= 1'b0;
         else if (power_on_event || watchdog_clear_instr || sleep_instr) to_q <= 1'b1;
         if (sleep_instr) pd_q <= 1'b0;
         else if (power_on_event || watchdog_clear_instr) pd_q <= 1'b1;
         if (power_on_event) por_q <= 1'b0;
         else if (fw_wr && wbyte[`BIT_POWER_ON]) por_q <= 1'b1;
         if (power_on_event || brownout_event) bor_q <= 1'b0;
         else if (fw_wr && wbyte[`BIT_BROWN_OUT]) bor_q <= 1'b1;
      end
   end

   // Last reset kind, one code per source (two for master clear, none for a watchdog time-out in power-managed mode), so firmware need not decode flags.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cause_q <= 4'h0;
      end else if (power_on_event) begin
         cause_q <= 4'h1;
      end else if (brownout_event) begin
         cause_q <= 4'h5;
      end else if (watchdog_timeout_event && !in_power_managed) begin
         cause_q <= 4'h4;
      end else if (reset_instr_event) begin
         cause_q <= 4'h6;
      end else if (stack_full_event) begin
         cause_q <= 4'h7;
      end else if (stack_underflow_event) begin
         cause_q <= 4'h8;
      end else if (master_clear_pin_q) begin
         cause_q <= in_power_managed ? 4'h3 : 4'h2;
      end
   end

   // ****************************************************************
   // Wake-exit sequencer
   // ****************************************************************
   wake_state_t ws_q;
   logic [31:0] csd_q, ost_q, pll_q, iob_q;
   logic        need_ost, need_pll, need_iob, any_busy;
   // Primary idle keeps the clock alive and external or internal sources need no start-up.
   assign need_ost = (pre_wake_clock != CLK_PRIMARY_IDLE)
                  && (post_wake_clock == OSC_CRYSTAL || post_wake_clock == OSC_PLL);
   assign need_pll = need_ost && (post_wake_clock == OSC_PLL);
   // The slow RC class is the 31 kHz source; the mux class spans 8 MHz and postscaled taps.
   assign need_iob = (post_wake_clock == OSC_INT)
                  && (pre_wake_clock == CLK_SLOW_RC || pre_wake_clock == CLK_NONE_SLEEP);
   // Only the CSD delay, start-up and PLL stall the CPU; oscillator settling runs beside execution.
   assign any_busy = (csd_q != 0) || (ost_q != 0) || (pll_q != 0);

   // All counters load at the wake edge; CSD, start-up and settling run together, but PLL lock waits for start-up to end.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ws_q  <= WS_RUN;
         csd_q <= 32'h0000_0000;
         ost_q <= 32'h0000_0000;
         pll_q <= 32'h0000_0000;
         iob_q <= 32'h0000_0000;
      end else begin
         case (ws_q)
            WS_RUN: begin
               if (wake_event) begin
                  csd_q <= 32'(CSD_CYCLES);
                  ost_q <= need_ost ? 32'(OST_CYCLES) : 32'h0000_0000;
                  pll_q <= need_pll ? 32'(PLL_CYCLES) : 32'h0000_0000;
                  iob_q <= need_iob ? 32'(IOBST_CYCLES) : 32'h0000_0000;
                  ws_q  <= WS_WAIT;
               end
            end
            WS_WAIT: begin
               if (csd_q != 0) csd_q <= csd_q - 32'h1;
               // Start-up counts oscillator periods; PLL lock follows it.
               if (ost_q != 0 && osc_tick) ost_q <= ost_q - 32'h1;
               else if (ost_q == 0 && pll_q != 0) pll_q <= pll_q - 32'h1;
               if (iob_q != 0) iob_q <= iob_q - 32'h1;
               if (!any_busy && iob_q == 0) ws_q <= WS_DONE;
            end
            WS_DONE: ws_q <= WS_RUN;
            default: ws_q <= WS_RUN;
         endcase
      end
   end
   // Execution resumes on the first clock after the longest stall delay.
   assign cpu_run = !device_reset && !(ws_q == WS_WAIT && any_busy);

   // Ready bits clear while the relevant oscillator is still starting.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         primary_clock_ready <= 1'b0;
         internal_osc_stable <= 1'b0;
      end else if (ws_q == WS_RUN && wake_event) begin
         primary_clock_ready <= (post_wake_clock != OSC_INT) && !need_ost;
         internal_osc_stable <= (post_wake_clock == OSC_INT) && !need_iob;
      end else if (ws_q == WS_WAIT) begin
         if (post_wake_clock != OSC_INT && ost_q == 0 && pll_q == 0) primary_clock_ready <= 1'b1;
         if (post_wake_clock == OSC_INT && iob_q == 0) internal_osc_stable <= 1'b1;
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   logic        aw_q, w_q;
   logic [11:0] awa_q;
   logic [7:0]  wd_q;
   logic        wstb_q;
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign wr_go = aw_q && w_q && !s_axi_bvalid;
   assign fw_wr = wr_go && wstb_q && (awa_q == `ADDR_RESET_CTRL);
   assign wbyte = wd_q;

   // Address and data are latched independently and joined for one response.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aw_q         <= 1'b0;
         w_q          <= 1'b0;
         awa_q        <= 12'h000;
         wd_q         <= 8'h00;
         wstb_q       <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q  <= 1'b1;
            awa_q <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q    <= 1'b1;
            wd_q   <= s_axi_wdata[7:0];
            wstb_q <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awa_q == `ADDR_RESET_CTRL) ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Reads return a registered word one cycle after the address is taken.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case ({s_axi_araddr[11:2], 2'b00})
            // Bit 5 is hard zero; bit 6 reads zero outside software mode.
            `ADDR_RESET_CTRL: s_axi_rdata <= {24'h000000, prio_q, soft_bor_q & soft_mode,
                                              1'b0, ri_q, to_q, pd_q, por_q, bor_q};
            `ADDR_WAKE_STATUS: s_axi_rdata <= {24'h000000, cause_q, internal_osc_stable,
                                               primary_clock_ready, cpu_run, brownout_active};
            `ADDR_CLOCK_CONFIG: s_axi_rdata <= {26'h0000000, master_clear_pin_enable,
                                                brownout_config_mode, 1'b0, ws_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- bench/master_clear_pin_driver.sv ----
// External master-clear pin driver with the board pull-up resistor.
`timescale 1ns/1ns
module master_clear_pin_driver (
   input  wire logic hold_low,
   output logic      pin
);
   // A released pin is pulled up, so the line never floats between pulses.
   assign pin = hold_low ? 1'b0 : 1'b1;
endmodule

// ---- bench/reset_status_wake_exit_props.sv ----
// Concurrent checks on the ports of the reset and wake block.
`timescale 1ns/1ns
module reset_status_wake_exit_props (
   input wire logic               mclk,
   input wire logic               reset_n,
   input wire logic               master_clear_pin_enable,
   input wire logic               master_clear_pin_in,
   input wire logic               master_clear_pin_out,
   input wire logic               master_clear_pin_oe,
   input wire logic               master_clear_digital_in,
   input wire logic               wake_event,
   input wire rst_pkg::pre_clk_t  pre_wake_clock,
   input wire rst_pkg::post_clk_t post_wake_clock,
   input wire logic               device_reset,
   input wire logic               cpu_run,
   input wire logic               internal_osc_stable,
   input wire logic               interrupt_priority_enable
);
   import rst_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   logic go;
   logic slow_post;
   // A wake counts for these checks only while the core runs and no reset is pending.
   assign go = wake_event && cpu_run && !device_reset;
   assign slow_post = post_wake_clock inside {OSC_CRYSTAL, OSC_PLL};

   a_pin_not_driven: assert property (
      !master_clear_pin_oe && !master_clear_pin_out) else $error("master clear pin driven");
   a_pin_as_input: assert property (
      !master_clear_pin_enable |-> master_clear_digital_in == master_clear_pin_in)
      else $error("digital input does not follow the pin");
   a_filter_asserts: assert property (
      (master_clear_pin_enable && !master_clear_pin_in) [*4] |-> ##[0:2] device_reset)
      else $error("held master clear gave no reset");
   a_reset_halts_cpu: assert property (
      device_reset |-> !cpu_run) else $error("core runs during reset");
   a_wake_min_delay: assert property (
      go |=> !cpu_run [*3]) else $error("core resumed before the wake delay");
   a_fast_exit: assert property (
      go && (pre_wake_clock == CLK_PRIMARY_IDLE || !slow_post) |-> ##[2:8] cpu_run)
      else $error("short exit took too long");
   a_crystal_startup: assert property (
      go && pre_wake_clock != CLK_PRIMARY_IDLE && slow_post |=> !cpu_run [*8])
      else $error("start-up wait skipped");
   a_stable_after_int: assert property (
      go && pre_wake_clock inside {CLK_SLOW_RC, CLK_NONE_SLEEP} && post_wake_clock == OSC_INT
      |-> ##[10:40] internal_osc_stable) else $error("oscillator stable flag missing");
   a_prio_reset_zero: assert property (
      $rose(reset_n) |-> !interrupt_priority_enable) else $error("priority enable not cleared");
endmodule

bind reset_status_wake_exit reset_status_wake_exit_props props (
   .mclk(mclk), .reset_n(reset_n), .master_clear_pin_enable(master_clear_pin_enable),
   .master_clear_pin_in(master_clear_pin_in), .master_clear_pin_out(master_clear_pin_out),
   .master_clear_pin_oe(master_clear_pin_oe), .master_clear_digital_in(master_clear_digital_in),
   .wake_event(wake_event), .pre_wake_clock(pre_wake_clock), .post_wake_clock(post_wake_clock),
   .device_reset(device_reset), .cpu_run(cpu_run), .internal_osc_stable(internal_osc_stable),
   .interrupt_priority_enable(interrupt_priority_enable)
);

// ---- bench/tb_top.sv ----
// Self-checking bench for the reset-cause register, pin filter and wake sequencer.
`timescale 1ns/1ns
module tb_top;
   import rst_pkg::*;
   logic        mclk = 0, reset_n = 0, tick = 0, wake = 0, in_pm = 0, pin_en = 1, hold_low = 0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, rst_seen = 0;
   logic        awready, wready, bvalid, arready, rvalid, pin, dig, dev_rst, cpu_run;
   logic        clk_ready, osc_stable, prio_en, bor_act;
   logic [1:0]  bresp, rresp, brown_cfg = 2'h1;
   logic [7:0]  ev = '0;
   logic [3:0]  cause;
   pre_clk_t    pre = CLK_SLOW_RC;
   post_clk_t   post = OSC_CRYSTAL;
   int          err_count = 0, tests_run = 0, cyc = 0;
   int          ev_bit [8] = '{2, 3, 6, 1, 0, 7, 4, 5};
   logic [4:0]  ev_flags [8] = '{5'h0F, 5'h17, 5'h1F, 5'h1E, 5'h1C, 5'h1A, 5'h1A, 5'h1A};
   logic [3:0]  ev_cause [8] = '{4'h6, 4'h4, 4'h4, 4'h5, 4'h1, 4'h1, 4'h7, 4'h8};
   pre_clk_t    wp [8] = '{CLK_SLOW_RC, CLK_PRIMARY_IDLE, CLK_SLOW_RC, CLK_PRIMARY_IDLE,
                           CLK_SLOW_RC, CLK_NONE_SLEEP, CLK_INT_OSC_MUX, CLK_NONE_SLEEP};
   post_clk_t   wq [8] = '{OSC_CRYSTAL, OSC_CRYSTAL, OSC_PLL, OSC_PLL,
                           OSC_EXT, OSC_INT, OSC_INT, OSC_CRYSTAL};

   // Short start-up and lock counts keep the wake runs brief.
   reset_status_wake_exit #(.PLL_CYCLES(8), .OST_CYCLES(8)) dut (
      .mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_on_event(ev[0]), .brownout_event(ev[1]), .reset_instr_event(ev[2]),
      .watchdog_timeout_event(ev[3]), .stack_full_event(ev[4]), .stack_underflow_event(ev[5]),
      .watchdog_clear_instr(ev[6]), .sleep_instr(ev[7]), .in_power_managed(in_pm),
      .brownout_config_mode(brown_cfg), .master_clear_pin_enable(pin_en),
      .master_clear_pin_in(pin), .master_clear_pin_out(), .master_clear_pin_oe(),
      .master_clear_digital_in(dig), .wake_event(wake), .pre_wake_clock(pre),
      .post_wake_clock(post), .osc_tick(tick), .device_reset(dev_rst), .cpu_run(cpu_run),
      .primary_clock_ready(clk_ready), .internal_osc_stable(osc_stable),
      .brownout_active(bor_act),
      .interrupt_priority_enable(prio_en), .reset_cause(cause));
   master_clear_pin_driver drv (.hold_low(hold_low), .pin(pin));

   // Clock, an oscillator strobe at half rate, a reset catcher and the hang limit.
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      tick <= ~tick;
      cyc <= cyc + 1;
      if (dev_rst) rst_seen <= 1'b1;
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // Ready is sampled at the falling edge, so the release lands on the taking edge.
   task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, b;
      int t;
      b = 0;
      t = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b && t < 60) begin
         @(negedge mclk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge mclk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
         t++;
      end
      if (!b) err_count++;
   endtask

   task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar, v;
      int t;
      v = 0;
      t = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!v && t < 60) begin
         @(negedge mclk);
         ar = arvalid && arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (ar) arvalid <= 1'b0;
         if (v) rready <= 1'b0;
         t++;
      end
      if (!v) err_count++;
   endtask

   // Holds the pin low for n sampled edges, then lets the filter settle.
   task automatic pin_low(input int n);
      @(posedge mclk);
      rst_seen <= 1'b0;
      hold_low <= 1'b1;
      repeat (n) @(posedge mclk);
      hold_low <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence: register map, reset events, pin filter, then wake exits.
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic        ok;
      int          n;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (2) @(posedge mclk);
      axr(12'h000, d, r);
      check("reset value", d, 32'h0000005C);
      axw(12'h000, 32'h000000FF, r);
      check("write resp", 32'(r), 32'h0);
      axr(12'h000, d, r);
      check("all set", d, 32'h000000DF);
      check("prio port", 32'(prio_en), 32'h1);
      check("soft brownout on", 32'(bor_act), 32'h1);
      @(posedge mclk) brown_cfg <= 2'h2;
      axr(12'h000, d, r);
      check("soft brownout masked", d, 32'h0000009F);
      @(posedge mclk) brown_cfg <= 2'h1;
      axw(12'h000, 32'h00000000, r);
      axr(12'h000, d, r);
      check("zero write", d, 32'h0000001F);
      check("soft brownout off", 32'(bor_act), 32'h0);
      axw(12'h004, 32'h000000FF, r);
      check("status write refused", 32'(r), 32'h2);
      axr(12'hFFC, d, r);
      check("unmapped resp", 32'(r), 32'h2);
      $display("test register map done");
      foreach (ev_bit[i]) begin
         axw(12'h000, 32'h00000012, r);
         @(posedge mclk) ev[ev_bit[i]] <= 1'b1;
         @(posedge mclk) ev <= 8'h00;
         repeat (4) @(posedge mclk);
         axr(12'h000, d, r);
         check("flags", 32'(d[4:0]), 32'(ev_flags[i]));
         check("cause", 32'(cause), 32'(ev_cause[i]));
      end
      $display("test reset events done");
      pin_low(2);
      check("short pulse", 32'(rst_seen), 32'h0);
      pin_low(6);
      check("long pulse", 32'(rst_seen), 32'h1);
      check("run pin cause", 32'(cause), 32'h2);
      @(posedge mclk) in_pm <= 1'b1;
      pin_low(6);
      check("idle pin cause", 32'(cause), 32'h3);
      @(posedge mclk) in_pm <= 1'b0;
      pin_en <= 1'b0;
      pin_low(6);
      check("disabled pin", 32'(rst_seen), 32'h0);
      @(negedge mclk) check("pin as input", 32'(dig), 32'h1);
      @(posedge mclk) pin_en <= 1'b1;
      $display("test master clear done");
      foreach (wp[i]) begin
         @(posedge mclk) pre <= wp[i];
         post <= wq[i];
         in_pm <= 1'b1;
         wake <= 1'b1;
         @(posedge mclk) wake <= 1'b0;
         in_pm <= 1'b0;
         n = 0;
         while (n < 60) begin
            @(negedge mclk);
            if (cpu_run === 1'b1) break;
            n++;
         end
         ok = (n >= 3 && n <= 6);
         if (wp[i] != CLK_PRIMARY_IDLE && wq[i] == OSC_CRYSTAL) ok = (n >= 14 && n <= 20);
         if (wp[i] != CLK_PRIMARY_IDLE && wq[i] == OSC_PLL) ok = (n >= 22 && n <= 30);
         check("exit delay", 32'(ok), 32'h1);
         repeat (20) @(negedge mclk);
         if (wq[i] == OSC_INT) check("osc stable", 32'(osc_stable), 32'h1);
         if (wq[i] inside {OSC_CRYSTAL, OSC_PLL}) check("ready", 32'(clk_ready), 32'h1);
      end
      $display("test wake exits done");
      final_report();
   end
endmodule
